// ### hdl/qurc_pkg.sv
package qurc_pkg;

    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] ADDR_CMD_A = 8'h81;
    localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h8f;
    localparam logic [7:0] ADDR_RST_STAT = 8'h9e;
    localparam logic [7:0] ADDR_CHAN_EN = 8'ha7;
    localparam logic [7:0] ADDR_MODE = 8'ha8;
    localparam logic [7:0] ADDR_BRG_RUN = 8'ha9;
    localparam logic [7:0] ADDR_WDOG_RUN = 8'haa;

    // command code that starts a full reset
    localparam logic [7:0] CMD_FULL_RESET = 8'h1f;

    // reset values
    localparam logic [7:0] GLOBAL_CFG_RST = 8'h00;
    localparam logic [7:0] CHAN_EN_RST = 8'h00;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [1:0] BRG_RUN_RST = 2'h0;
    localparam logic WDOG_RUN_RST = 1'b0;

    // field positions
    localparam int GLOBAL_CFG_SYNC_BIT = 1;
    localparam int CHAN_TX_LSB = 0;
    localparam int CHAN_RX_LSB = 4;
    localparam int MODE_IRQ_EN_BIT = 0;
    localparam int MODE_PDOWN_BIT = 1;
    localparam int MODE_TEST_BIT = 2;
    localparam int MODE_CHG_BIT = 3;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_PIN_BIT = 2;

    // clear vector positions
    localparam int CLR_CHAN_IRQ = 0;
    localparam int CLR_GLOBAL = 1;
    localparam int CLR_IO_CFG = 2;
    localparam int CLR_MODES = 3;
    localparam int CLR_BRG_CNT = 4;
    localparam int CLR_W = 5;

    // timing counts in bus clock cycles
    localparam logic [3:0] PIN_MIN_CYCLES = 4'ha;
    localparam logic [3:0] HOLDOFF_CYCLES = 4'h6;
    localparam logic [3:0] CMD_RST_CYCLES = 4'h4;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_CMD = 2'b01,
        ST_HOLD = 2'b10
    } qurc_state_t;

endpackage

// ### hdl/qurc_reset_ctrl.sv
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - pin reset and command 1f to the channel a command register run the same reset.
// - reset clears channel status, irq status, irq mask, xon irq status and irq control.
// - reset clears the global chip config, leaving the bus in asynchronous mode.
// - reset clears current irq, baud timer run, watchdog run and baud counter registers.
// - reset clears each io port config so all general pins become inputs.
// - reset leaves power-down and test modes and clears input change bits.
// - reset ends gang write, disables xon/xoff/address detect and clears rx errors.
// - reset disables transmitters, receivers and interrupt generation until re-enabled.
// - reset stops the baud rate counters.
// - a pin reset or RST_I aborts a bus cycle; a command reset lets it finish.
module qurc_reset_ctrl
    import qurc_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic RESET_PIN_N_I,
    // register port
    input wire logic [ADDR_W-1:0] BUS_ADDR_I,
    input wire logic [DATA_W-1:0] BUS_WDATA_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    output logic [DATA_W-1:0] BUS_RDATA_O,
    // reset to the rest of the device
    output logic DEV_RST_O,
    output logic [CLR_W-1:0] CLR_O,
    output logic HOLDOFF_O,
    // controls held by this block
    output logic BUS_SYNC_MODE_O,
    output logic [3:0] TX_EN_O,
    output logic [3:0] RX_EN_O,
    output logic IRQ_EN_O,
    output logic POWER_DOWN_O,
    output logic TEST_MODE_O,
    output logic CHG_DETECT_EN_O,
    output logic [1:0] BRG_RUN_O,
    output logic WDOG_RUN_O
);

    ////////////////////////////////////////////////////////////////////////////
    // pin reset synchroniser

    logic pin_rst;

    qurc_rst_sync u_sync (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_PIN_N_I),
        .rst_o(pin_rst)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer

    qurc_state_t state;
    logic [3:0] cnt;
    logic from_pin;
    logic cmd_hit;
    logic dev_rst;

    assign cmd_hit = BUS_WR_I && (BUS_ADDR_I == ADDR_CMD_A)
        && (BUS_WDATA_I == CMD_FULL_RESET);

    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            state <= ST_HOLD;
            cnt <= HOLDOFF_CYCLES - 4'h1;
        end else if (RST_I) begin
            state <= ST_HOLD;
            cnt <= HOLDOFF_CYCLES - 4'h1;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (cmd_hit) begin
                        state <= ST_CMD;
                        cnt <= CMD_RST_CYCLES - 4'h1;
                    end
                end
                ST_CMD: begin
                    if (cnt == 4'h0) begin
                        state <= ST_HOLD;
                        cnt <= HOLDOFF_CYCLES - 4'h1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                ST_HOLD: begin
                    if (cmd_hit) begin
                        state <= ST_CMD;
                        cnt <= CMD_RST_CYCLES - 4'h1;
                    end else if (cnt == 4'h0) begin
                        state <= ST_RUN;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= ST_HOLD;
                    cnt <= HOLDOFF_CYCLES - 4'h1;
                end
            endcase
        end
    end

    // remembers whether the last reset came from the pin or RST_I rather than a command
    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            from_pin <= 1'b1;
        end else if (RST_I) begin
            from_pin <= 1'b1;
        end else if (cmd_hit && state != ST_CMD) begin
            from_pin <= 1'b0;
        end
    end

    assign dev_rst = pin_rst || RST_I || (state == ST_CMD);
    assign DEV_RST_O = dev_rst;
    assign CLR_O = {CLR_W{dev_rst}};
    assign HOLDOFF_O = (state == ST_HOLD) && !pin_rst;

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] global_cfg;
    logic [7:0] chan_en;
    logic [3:0] mode;
    logic [1:0] brg_run;
    logic wdog_run;

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
        wr_hit = BUS_WR_I && (a == target);
    endfunction

    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            global_cfg <= GLOBAL_CFG_RST;
        end else if (dev_rst) begin
            global_cfg <= GLOBAL_CFG_RST;
        end else if (wr_hit(BUS_ADDR_I, ADDR_GLOBAL_CFG)) begin
            global_cfg <= BUS_WDATA_I;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            chan_en <= CHAN_EN_RST;
        end else if (dev_rst) begin
            chan_en <= CHAN_EN_RST;
        end else if (wr_hit(BUS_ADDR_I, ADDR_CHAN_EN)) begin
            chan_en <= BUS_WDATA_I;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            mode <= MODE_RST;
        end else if (dev_rst) begin
            mode <= MODE_RST;
        end else if (wr_hit(BUS_ADDR_I, ADDR_MODE)) begin
            mode <= BUS_WDATA_I[3:0];
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            brg_run <= BRG_RUN_RST;
            wdog_run <= WDOG_RUN_RST;
        end else if (dev_rst) begin
            brg_run <= BRG_RUN_RST;
            wdog_run <= WDOG_RUN_RST;
        end else begin
            if (wr_hit(BUS_ADDR_I, ADDR_BRG_RUN)) begin
                brg_run <= BUS_WDATA_I[1:0];
            end
            if (wr_hit(BUS_ADDR_I, ADDR_WDOG_RUN)) begin
                wdog_run <= BUS_WDATA_I[0];
            end
        end
    end

    assign BUS_SYNC_MODE_O = global_cfg[GLOBAL_CFG_SYNC_BIT];
    assign TX_EN_O = chan_en[CHAN_TX_LSB +: 4];
    assign RX_EN_O = chan_en[CHAN_RX_LSB +: 4];
    assign IRQ_EN_O = mode[MODE_IRQ_EN_BIT];
    assign POWER_DOWN_O = mode[MODE_PDOWN_BIT];
    assign TEST_MODE_O = mode[MODE_TEST_BIT];
    assign CHG_DETECT_EN_O = mode[MODE_CHG_BIT];
    assign BRG_RUN_O = brg_run;
    assign WDOG_RUN_O = wdog_run;

    ////////////////////////////////////////////////////////////////////////////
    // read port

    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (BUS_ADDR_I)
            ADDR_GLOBAL_CFG: rd_mux = global_cfg;
            ADDR_CHAN_EN: rd_mux = chan_en;
            ADDR_MODE: rd_mux = {4'h0, mode};
            ADDR_BRG_RUN: rd_mux = {6'h00, brg_run};
            ADDR_WDOG_RUN: rd_mux = {7'h00, wdog_run};
            ADDR_RST_STAT: begin
                rd_mux[STAT_ACTIVE_BIT] = dev_rst;
                rd_mux[STAT_HOLD_BIT] = HOLDOFF_O;
                rd_mux[STAT_PIN_BIT] = from_pin;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    // a pin reset drops the read in flight; a command reset does not touch it
    always_ff @(posedge CORE_CLK_I or posedge pin_rst) begin
        if (pin_rst) begin
            BUS_RDATA_O <= 8'h00;
        end else if (RST_I) begin
            BUS_RDATA_O <= 8'h00;
        end else if (BUS_RD_I) begin
            BUS_RDATA_O <= rd_mux;
        end else begin
            BUS_RDATA_O <= 8'h00;
        end
    end

endmodule

// ### hdl/qurc_rst_sync.sv
`timescale 1ns/1ps
module qurc_rst_sync (
    // clock
    input wire logic clk_i,
    // asynchronous active-low reset pin
    input wire logic rst_n_i,
    // reset, set at once, released on a clock edge
    output logic rst_o
);
    logic meta;
    logic sync;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b1;
            sync <= 1'b1;
        end else begin
            meta <= 1'b0;
            sync <= meta;
        end
    end

    assign rst_o = sync;
endmodule

// ### verif/qurc_host_model.sv
`timescale 1ns/1ps
module qurc_host_model
    import qurc_pkg::*;
(
    // clock and status
    input wire logic clk_i,
    input wire logic holdoff_i,
    input wire logic dev_rst_i,
    // pin and bus
    output logic pin_n_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    logic [7:0] exp_q[$];
    logic timed_out = 1'b0;
    initial begin
        pin_n_o = 1'b1;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // one strobe cycle; a read notes its expected data
    task automatic op(input logic we, input logic [7:0] a, input logic [7:0] d);
        wr_o <= we;
        rd_o <= !we;
        addr_o <= a;
        wdata_o <= d;
        if (!we) exp_q.push_back(d);
        @(posedge clk_i);
    endtask
    // released lines show the inverse of their last value
    task automatic idle();
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
        @(posedge clk_i);
    endtask
    task automatic regs(input logic we, input logic [7:0] g, c, m, b, d);
        if (we) op(1'b1, ADDR_GLOBAL_CFG, g);
        op(we, ADDR_CHAN_EN, c);
        op(we, ADDR_MODE, we ? m : {4'h0, m[3:0]});
        op(we, ADDR_BRG_RUN, we ? b : {6'h00, b[1:0]});
        op(we, ADDR_WDOG_RUN, we ? d : {7'h00, d[0]});
        if (!we) op(1'b0, 8'h00, 8'h00);
        idle();
    endtask
    task automatic pin_reset();
        pin_n_o <= 1'b0;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        repeat (PIN_MIN_CYCLES) @(posedge clk_i);
        pin_n_o <= 1'b1;
    endtask
    // no access until reset and holdoff are over
    task automatic settle();
        int i;
        for (i = 0; i < 20 && (dev_rst_i || holdoff_i); i++) @(posedge clk_i);
        if (i == 20) timed_out = 1'b1;
    endtask
endmodule

// ### verif/qurc_reset_ctrl_tb.sv
`timescale 1ns/1ps
module qurc_reset_ctrl_tb
    import qurc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd_d = 1'b0;
    logic pin_n, wr, rd, dev, hold, sync, irq, pd, tm, chg, wd;
    logic [7:0] addr, wdata, rdata, g, c, m, b, w;
    logic [3:0] tx, rx;
    logic [1:0] brg;
    int failures = 0;
    int n_compared = 0;
    int k;
    wire [15:0] ctl = {sync, rx, tx, chg, tm, pd, irq, brg, wd};
    always #2 clk = ~clk;
    qurc_reset_ctrl qurc_reset_ctrl_i (.CORE_CLK_I(clk), .RST_I(rst), .RESET_PIN_N_I(pin_n),
        .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata), .BUS_WR_I(wr), .BUS_RD_I(rd),
        .BUS_RDATA_O(rdata), .DEV_RST_O(dev), .CLR_O(), .HOLDOFF_O(hold),
        .BUS_SYNC_MODE_O(sync), .TX_EN_O(tx), .RX_EN_O(rx), .IRQ_EN_O(irq),
        .POWER_DOWN_O(pd), .TEST_MODE_O(tm), .CHG_DETECT_EN_O(chg), .BRG_RUN_O(brg),
        .WDOG_RUN_O(wd));
    qurc_host_model qurc_host_model_i (.clk_i(clk), .holdoff_i(hold), .dev_rst_i(dev),
        .pin_n_o(pin_n), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // read data stands in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d && qurc_host_model_i.exp_q.size() > 0)
            chk({8'h00, rdata}, {8'h00, qurc_host_model_i.exp_q.pop_front()});
        rd_d <= rd;
    end
    always @(posedge qurc_host_model_i.timed_out) begin
        failures++;
        end_sim();
    end
    initial begin
        #20000;
        failures++;
        end_sim();
    end
    initial begin
        void'($urandom(55));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        qurc_host_model_i.settle();
        for (k = 0; k < 3; k++) begin
            g = 8'($urandom);
            c = 8'($urandom);
            m = 8'($urandom);
            b = 8'($urandom);
            w = 8'($urandom);
            qurc_host_model_i.regs(1'b1, g, c, m, b, w);
            qurc_host_model_i.op(1'b1, ADDR_CMD_A, 8'h1e);
            qurc_host_model_i.regs(1'b0, g, c, m, b, w);
            chk(ctl, {g[GLOBAL_CFG_SYNC_BIT], c, m[3:0], b[1:0], w[0]});
            qurc_host_model_i.op(1'b0, ADDR_CHAN_EN, k == 1 ? 8'h00 : c);
            if (k == 0) qurc_host_model_i.op(1'b1, ADDR_CMD_A, CMD_FULL_RESET);
            if (k == 1) qurc_host_model_i.pin_reset();
            if (k == 2) rst <= 1'b1;
            qurc_host_model_i.idle();
            rst <= 1'b0;
            qurc_host_model_i.settle();
            chk(ctl, 16'h0000);
            qurc_host_model_i.op(1'b0, ADDR_RST_STAT, {5'h00, k != 0, 2'b00});
            qurc_host_model_i.regs(1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        end
        qurc_host_model_i.idle();
        end_sim();
    end
endmodule

// ### verif/qurc_reset_monitor.sv
`timescale 1ns/1ps
module qurc_reset_monitor
    import qurc_pkg::*;
(
    // clock and resets
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic RESET_PIN_N_I,
    // bus
    input wire logic [ADDR_W-1:0] BUS_ADDR_I,
    input wire logic [DATA_W-1:0] BUS_WDATA_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    input wire logic [DATA_W-1:0] BUS_RDATA_O,
    // reset outputs and controls
    input wire logic DEV_RST_O,
    input wire logic [CLR_W-1:0] CLR_O,
    input wire logic HOLDOFF_O,
    input wire logic BUS_SYNC_MODE_O,
    input wire logic [3:0] TX_EN_O,
    input wire logic [3:0] RX_EN_O,
    input wire logic IRQ_EN_O,
    input wire logic POWER_DOWN_O,
    input wire logic TEST_MODE_O,
    input wire logic CHG_DETECT_EN_O,
    input wire logic [1:0] BRG_RUN_O,
    input wire logic WDOG_RUN_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_PIN_N_I);
    // no history exists before the first edge
    logic started = 1'b0;
    always @(posedge CORE_CLK_I) started <= 1'b1;
    wire cmd = BUS_WR_I && BUS_ADDR_I == ADDR_CMD_A && BUS_WDATA_I == CMD_FULL_RESET;
    wire any_ctl = |{BUS_SYNC_MODE_O, TX_EN_O, RX_EN_O, IRQ_EN_O, POWER_DOWN_O,
        TEST_MODE_O, CHG_DETECT_EN_O, BRG_RUN_O, WDOG_RUN_O};
    cmd_reset_a: assert property (cmd && !DEV_RST_O && !HOLDOFF_O |=> DEV_RST_O[*4] ##1
        (!DEV_RST_O && HOLDOFF_O)[*6] ##1 !HOLDOFF_O) else $error("command reset bad");
    clr_lines_a: assert property (CLR_O == {CLR_W{DEV_RST_O}})
        else $error("clear lines bad");
    ctl_clear_a: assert property (started && DEV_RST_O && $past(DEV_RST_O) |-> !any_ctl)
        else $error("control set in reset");
    pin_reset_a: assert property (disable iff (1'b0) !RESET_PIN_N_I |-> DEV_RST_O &&
        !any_ctl && BUS_RDATA_O == '0) else $error("pin reset late");
    pin_release_a: assert property ($rose(RESET_PIN_N_I) && !RST_I |-> DEV_RST_O
        ##1 DEV_RST_O ##1 !DEV_RST_O) else $error("release edge bad");
    sync_reset_a: assert property (RST_I |-> DEV_RST_O) else $error("sync reset lost");
    holdoff_len_a: assert property ($fell(DEV_RST_O) |-> HOLDOFF_O[*6] ##1 !HOLDOFF_O)
        else $error("holdoff length bad");
    rd_idle_a: assert property (started && !$past(BUS_RD_I) |-> BUS_RDATA_O == '0)
        else $error("stray read data");
    rd_chan_a: assert property (BUS_RD_I && BUS_ADDR_I == ADDR_CHAN_EN && !DEV_RST_O |=>
        BUS_RDATA_O == $past({RX_EN_O, TX_EN_O})) else $error("enable read bad");
    cmd_seen_c: cover property (cmd && !DEV_RST_O);
    pin_seen_c: cover property ($rose(RESET_PIN_N_I));
    rd_seen_c: cover property (BUS_RD_I && BUS_ADDR_I == ADDR_CHAN_EN);
endmodule

bind qurc_reset_ctrl qurc_reset_monitor qurc_reset_monitor_i (.*);
